//--- rtl/rsc_top.sv
`include "rsc_cfg.svh"

// ---------------------------------------------
// token buffer
// ---------------------------------------------
module rsc_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad
		$error("rsc_fifo: DEPTH must be at least 2");
	end
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] rd;
		logic [PW-1:0] wr;
		logic [PW:0] cnt;
	} rsc_fifo_state_type;
	rsc_fifo_state_type q, s;
	logic do_in, do_out;
	assign in_ready = (q.cnt != (PW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rd];
	assign do_in = in_valid & in_ready;
	assign do_out = out_valid & out_ready;
	always_comb begin
		s = q;
		if (do_in) begin
			s.mem[q.wr] = in_data;
			s.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
		end
		if (do_out) begin
			s.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
		end
		if (do_in && !do_out) begin
			s.cnt = q.cnt + 1'b1;
		end else if (!do_in && do_out) begin
			s.cnt = q.cnt - 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= s;
		end
	end
endmodule // rsc_fifo

// How it works
// - status byte returned during command byte
// - command MSB first, data LSByte first
// - 000+address reads one to five bytes
// - 001+address writes, only in standby/power-down
// - payload read from byte zero, then removed
// - payload write stores from byte zero
// - flush codes empty transmit or receive FIFO
// - resend code repeats last payload until cleared, transmitter mode only
// - width query returns oldest receive entry width
// - ack payload per pipe, receiver mode only
// - no-ack payload write in transmitter mode
// - no-operation code only returns status
// - width, ack, no-ack need feature enables
// - short register write updates received bytes only
// - status shifted out after select falls
// - pipe field updates as interrupt falls
// - three-entry, 32-byte transmit and receive FIFOs
// - receiver transmit FIFO stalls on lost links
// - retry limit keeps unsent payload queued
// - full, empty and reuse flags exposed
// - masked sticky flags drive interrupt, write-one clears
// - controller byte FIFOs follow ready flags
module rsc_top
	import rsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic radio_select_n,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	output logic spi_miso,
	input wire logic [7:0] reg_rd_data,
	output logic [4:0] reg_rd_addr,
	output logic [2:0] reg_rd_byte,
	output logic reg_wr_en,
	output logic [4:0] reg_wr_addr,
	output logic [39:0] reg_wr_data,
	output logic [4:0] reg_wr_mask,
	input wire logic radio_standby,
	input wire logic primary_receiver_mode,
	input wire logic feature_width_en,
	input wire logic feature_ack_pay_en,
	input wire logic feature_noack_en,
	input wire logic mask_received,
	input wire logic mask_sent,
	input wire logic mask_retry,
	input wire logic ev_sent,
	input wire logic ev_received,
	input wire logic ev_retry_limit,
	input wire logic [2:0] rx_pipe_in,
	input wire logic [4:0] tx_rd_idx,
	output logic [7:0] tx_rd_byte,
	output logic [5:0] tx_head_width,
	output logic tx_head_noack,
	output logic tx_head_is_ack,
	output logic [2:0] tx_head_pipe,
	input wire logic tx_sent_pop,
	input wire logic [5:0] pipe_link_lost,
	output logic tx_stalled,
	input wire logic rx_wr_en,
	input wire logic [4:0] rx_wr_idx,
	input wire logic [7:0] rx_wr_byte,
	input wire logic rx_commit,
	input wire logic [5:0] rx_commit_width,
	input wire logic [2:0] rx_commit_pipe,
	output logic tx_full,
	output logic tx_empty,
	output logic rx_full,
	output logic rx_empty,
	output logic reuse_active,
	output logic [7:0] status_byte,
	output logic radio_interrupt_line_n,
	output logic cmd_fifo_ready
);
	typedef struct packed {
		logic [2:0] csn_s;
		logic [2:0] sck_s;
		logic [2:0] mosi_s;
		logic [7:0] sh_in;
		logic [2:0] bit_cnt;
		logic first;
		logic [7:0] cmd_rd;
		logic [5:0] data_cnt;
		logic [7:0] sh_out;
		logic miso;
		rsc_class_type cl;
		logic [2:0] ex_pipe;
		logic [4:0] ex_addr;
		logic [5:0] widx;
		logic [4:0][7:0] wbuf;
		logic [4:0] wmask;
		logic cool;
		logic wr_en;
		logic [4:0] wr_addr;
		logic [39:0] wr_data;
		logic [4:0] wr_mask;
		rsc_mem_type tx_mem;
		logic [2:0][5:0] tx_wid;
		logic [2:0] tx_noack;
		logic [2:0] tx_ack;
		logic [2:0][2:0] tx_pipe;
		logic [1:0] tx_rd;
		logic [1:0] tx_wr;
		logic [1:0] tx_cnt;
		rsc_mem_type rx_mem;
		logic [2:0][5:0] rx_wid;
		logic [2:0][2:0] rx_pipe;
		logic [1:0] rx_rd;
		logic [1:0] rx_wr;
		logic [1:0] rx_cnt;
		logic reuse;
		logic [2:0] flags;
		logic [2:0] pipe;
		logic irq_n;
		logic [7:0] tx_byte;
	} rsc_state_type;

	rsc_state_type q, s;
	logic [1:0] rst_sync_r;
	logic rst_int_n;
	logic tok_in_v, tok_in_rdy, tok_out_v, tok_out_rdy;
	logic [9:0] tok_in_d, tok_out_d;
	logic [7:0] rd_src, tok_byte;
	logic csn_fall, csn_rise, sck_rise, sck_fall, byte_done;
	logic [7:0] byte_in;
	logic tx_inc, tx_dec, tx_flush, rx_inc, rx_dec, rx_flush;
	logic [2:0] flag_set, flag_clr;
	logic irq_act, all_lost;
	rsc_tok_type tok_kind;

	function automatic logic [1:0] rsc_inc3(input logic [1:0] p);
		rsc_inc3 = (p == 2'h2) ? 2'h0 : p + 2'h1;
	endfunction

	// ---------------------------------------------
	// reset release
	// ---------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync_r[1];

	// ---------------------------------------------
	// token buffer between serial side and executor
	// ---------------------------------------------
	rsc_fifo #(.WIDTH(10), .DEPTH(`RSC_TOKEN_FIFO_DEPTH)) u_tok (
		.clk(clk),
		.rst_n(rst_int_n),
		.in_valid(tok_in_v),
		.in_ready(tok_in_rdy),
		.in_data(tok_in_d),
		.out_valid(tok_out_v),
		.out_ready(tok_out_rdy),
		.out_data(tok_out_d)
	);
	assign cmd_fifo_ready = tok_in_rdy;
	assign tok_out_rdy = ~q.cool;
	assign tok_kind = rsc_tok_type'(tok_out_d[9:8]);
	assign tok_byte = tok_out_d[7:0];

	// ---------------------------------------------
	// serial edges and read source
	// ---------------------------------------------
	assign csn_fall = q.csn_s[2] & ~q.csn_s[1];
	assign csn_rise = ~q.csn_s[2] & q.csn_s[1];
	assign sck_rise = ~q.csn_s[1] & ~q.sck_s[2] & q.sck_s[1];
	assign sck_fall = ~q.csn_s[1] & q.sck_s[2] & ~q.sck_s[1];
	assign byte_in = {q.sh_in[6:0], q.mosi_s[1]};
	assign byte_done = sck_rise & (q.bit_cnt == 3'h7);
	assign tok_in_v = byte_done | csn_rise;
	assign tok_in_d = csn_rise ? {RSC_TOK_END, 8'h00} :
		{(q.first ? RSC_TOK_CMD : RSC_TOK_DATA), byte_in};

	always_comb begin
		rd_src = `RSC_IDLE_READ_BYTE;
		if (q.cmd_rd[7:5] == `RSC_CMD_RD_REG_TOP) begin
			rd_src = reg_rd_data;
		end else if (q.cmd_rd == `RSC_CMD_RD_PAYLOAD) begin
			if (q.rx_cnt != 2'h0 && q.data_cnt < `RSC_PAYLOAD_BYTES) begin
				rd_src = q.rx_mem[q.rx_rd][q.data_cnt[4:0]];
			end
		end else if (q.cmd_rd == `RSC_CMD_RX_WIDTH) begin
			if (feature_width_en && q.rx_cnt != 2'h0 && q.data_cnt == 6'h00) begin
				rd_src = {2'h0, q.rx_wid[q.rx_rd]};
			end
		end
	end

	// in receiver mode, transmit FIFO stalls when every pending entry aims at a lost pipe
	always_comb begin
		logic [1:0] p;
		p = q.tx_rd;
		all_lost = primary_receiver_mode && (q.tx_cnt != 2'h0);
		for (int i = 0; i < 3; i++) begin
			if (2'(i) < q.tx_cnt) begin
				if (!(q.tx_pipe[p] <= `RSC_ACK_PIPE_MAX && pipe_link_lost[q.tx_pipe[p]])) begin
					all_lost = 1'b0;
				end
			end
			p = rsc_inc3(p);
		end
	end

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		s = q;
		tx_inc = 1'b0;
		tx_flush = 1'b0;
		rx_flush = 1'b0;
		rx_dec = 1'b0;
		flag_clr = 3'h0;
		s.wr_en = 1'b0;
		s.cool = 1'b0;
		s.csn_s = {q.csn_s[1], q.csn_s[0], radio_select_n};
		s.sck_s = {q.sck_s[1], q.sck_s[0], spi_sck};
		s.mosi_s = {q.mosi_s[1], q.mosi_s[0], spi_mosi};
		// serial shifter
		if (csn_fall) begin
			s.sh_out = status_byte;
			s.miso = status_byte[7];
			s.bit_cnt = 3'h0;
			s.first = 1'b1;
			s.data_cnt = 6'h00;
			s.cmd_rd = `RSC_CMD_NO_OPERATION;
		end
		if (csn_rise) begin
			s.bit_cnt = 3'h0;
			s.first = 1'b0;
			if (q.cmd_rd == `RSC_CMD_RD_PAYLOAD && q.data_cnt != 6'h00 && q.rx_cnt != 2'h0) begin
				rx_dec = 1'b1;
			end
			s.cmd_rd = `RSC_CMD_NO_OPERATION;
		end
		if (sck_rise) begin
			s.sh_in = byte_in;
			s.bit_cnt = q.bit_cnt + 3'h1;
			if (byte_done) begin
				if (q.first) begin
					s.cmd_rd = byte_in;
					s.first = 1'b0;
					s.data_cnt = 6'h00;
				end else if (q.data_cnt != 6'h3F) begin
					s.data_cnt = q.data_cnt + 6'h01;
				end
			end
		end
		if (sck_fall) begin
			if (q.bit_cnt == 3'h0) begin
				s.sh_out = rd_src;
				s.miso = rd_src[7];
			end else begin
				s.sh_out = {q.sh_out[6:0], 1'b0};
				s.miso = q.sh_out[6];
			end
		end
		// executor
		if (tok_out_v && tok_out_rdy) begin
			case (tok_kind)
				RSC_TOK_CMD: begin
					s.widx = 6'h00;
					s.wmask = 5'h00;
					s.ex_addr = tok_byte[4:0];
					s.ex_pipe = tok_byte[2:0];
					s.cl = RSC_CL_NONE;
					if (tok_byte[7:5] == `RSC_CMD_WR_REG_TOP && radio_standby) begin
						s.cl = RSC_CL_REG_WR;
					end else if (tok_byte == `RSC_CMD_WR_PAYLOAD) begin
						s.cl = RSC_CL_TX_PAY;
						s.reuse = 1'b0;
					end else if (tok_byte[7:3] == `RSC_CMD_ACK_PAY_TOP) begin
						if (feature_ack_pay_en && primary_receiver_mode && tok_byte[2:0] <= `RSC_ACK_PIPE_MAX) begin
							s.cl = RSC_CL_ACK_PAY;
						end
					end else if (tok_byte == `RSC_CMD_WR_NOACK) begin
						if (feature_noack_en && !primary_receiver_mode) begin
							s.cl = RSC_CL_NOACK_PAY;
						end
					end else if (tok_byte == `RSC_CMD_FLUSH_TX) begin
						tx_flush = 1'b1;
						s.reuse = 1'b0;
					end else if (tok_byte == `RSC_CMD_FLUSH_RX) begin
						rx_flush = 1'b1;
					end else if (tok_byte == `RSC_CMD_RESEND_LAST) begin
						s.reuse = ~primary_receiver_mode;
					end
				end
				RSC_TOK_DATA: begin
					if (q.cl == RSC_CL_REG_WR) begin
						if (q.widx < `RSC_REG_BYTES_MAX) begin
							s.wbuf[q.widx[2:0]] = tok_byte;
							s.wmask[q.widx[2:0]] = 1'b1;
							s.widx = q.widx + 6'h01;
						end
					end else if (q.cl != RSC_CL_NONE) begin
						if (q.widx < `RSC_PAYLOAD_BYTES && q.tx_cnt != `RSC_FIFO_LEVELS) begin
							s.tx_mem[q.tx_wr][q.widx[4:0]] = tok_byte;
							s.widx = q.widx + 6'h01;
						end
					end
				end
				RSC_TOK_END: begin
					s.cool = 1'b1;
					if (q.cl == RSC_CL_REG_WR && q.wmask != 5'h00) begin
						s.wr_en = 1'b1;
						s.wr_addr = q.ex_addr;
						s.wr_data = q.wbuf;
						s.wr_mask = q.wmask;
						if (q.ex_addr == `RSC_STATUS_REG_ADDR) begin
							flag_clr = {q.wbuf[0][`RSC_STATUS_RECEIVED_BIT], q.wbuf[0][`RSC_STATUS_SENT_BIT],
								q.wbuf[0][`RSC_STATUS_RETRY_BIT]};
						end
					end else if (q.cl != RSC_CL_NONE && q.cl != RSC_CL_REG_WR && q.widx != 6'h00 &&
						q.tx_cnt != `RSC_FIFO_LEVELS) begin
						tx_inc = 1'b1;
						s.tx_wid[q.tx_wr] = q.widx;
						s.tx_noack[q.tx_wr] = (q.cl == RSC_CL_NOACK_PAY);
						s.tx_ack[q.tx_wr] = (q.cl == RSC_CL_ACK_PAY);
						s.tx_pipe[q.tx_wr] = q.ex_pipe;
					end
					s.cl = RSC_CL_NONE;
				end
				default: begin
					s.cl = RSC_CL_NONE;
				end
			endcase
		end
		// transmit FIFO bookkeeping
		tx_dec = tx_sent_pop && !q.reuse && !q.flags[0] && q.tx_cnt != 2'h0;
		if (tx_flush) begin
			s.tx_cnt = 2'h0;
			s.tx_rd = 2'h0;
			s.tx_wr = 2'h0;
		end else begin
			if (tx_inc) begin
				s.tx_wr = rsc_inc3(q.tx_wr);
			end
			if (tx_dec) begin
				s.tx_rd = rsc_inc3(q.tx_rd);
			end
			s.tx_cnt = q.tx_cnt + {1'b0, tx_inc} - {1'b0, tx_dec};
		end
		s.tx_byte = q.tx_mem[q.tx_rd][tx_rd_idx];
		// receive FIFO bookkeeping
		rx_inc = rx_commit && q.rx_cnt != `RSC_FIFO_LEVELS;
		if (rx_wr_en && q.rx_cnt != `RSC_FIFO_LEVELS) begin
			s.rx_mem[q.rx_wr][rx_wr_idx] = rx_wr_byte;
		end
		if (rx_flush) begin
			s.rx_cnt = 2'h0;
			s.rx_rd = 2'h0;
			s.rx_wr = 2'h0;
		end else begin
			if (rx_inc) begin
				s.rx_wid[q.rx_wr] = rx_commit_width;
				s.rx_pipe[q.rx_wr] = rx_commit_pipe;
				s.rx_wr = rsc_inc3(q.rx_wr);
			end
			if (rx_dec) begin
				s.rx_rd = rsc_inc3(q.rx_rd);
			end
			s.rx_cnt = q.rx_cnt + {1'b0, rx_inc} - {1'b0, rx_dec};
		end
		// sticky flags, set wins over clear
		flag_set = {ev_received, ev_sent, ev_retry_limit};
		s.flags = (q.flags & ~flag_clr) | flag_set;
		irq_act = |(s.flags & ~{mask_received, mask_sent, mask_retry});
		s.irq_n = ~irq_act;
		if (irq_act && q.irq_n) begin
			s.pipe = rx_pipe_in;
		end
	end

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			q <= '0;
			q.csn_s <= 3'h7;
			q.cmd_rd <= `RSC_CMD_NO_OPERATION;
			q.cl <= RSC_CL_NONE;
			q.pipe <= `RSC_PIPE_RESET;
			q.irq_n <= 1'b1;
		end else begin
			q <= s;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign spi_miso = q.miso;
	assign reg_rd_addr = q.cmd_rd[4:0];
	assign reg_rd_byte = q.data_cnt[2:0];
	assign reg_wr_en = q.wr_en;
	assign reg_wr_addr = q.wr_addr;
	assign reg_wr_data = q.wr_data;
	assign reg_wr_mask = q.wr_mask;
	assign tx_rd_byte = q.tx_byte;
	assign tx_head_width = q.tx_wid[q.tx_rd];
	assign tx_head_noack = q.tx_noack[q.tx_rd];
	assign tx_head_is_ack = q.tx_ack[q.tx_rd];
	assign tx_head_pipe = q.tx_pipe[q.tx_rd];
	assign tx_stalled = all_lost;
	assign tx_full = (q.tx_cnt == `RSC_FIFO_LEVELS);
	assign tx_empty = (q.tx_cnt == 2'h0);
	assign rx_full = (q.rx_cnt == `RSC_FIFO_LEVELS);
	assign rx_empty = (q.rx_cnt == 2'h0);
	assign reuse_active = q.reuse;
	assign status_byte = {1'b0, q.flags, q.pipe, tx_full};
	assign radio_interrupt_line_n = q.irq_n;
endmodule // rsc_top

//--- rtl/rsc_cfg.svh
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
// ---------------------------------------------
// command codes
// ---------------------------------------------
`define RSC_CMD_RD_REG_TOP 3'h0
`define RSC_CMD_WR_REG_TOP 3'h1
`define RSC_CMD_RD_PAYLOAD 8'h61
`define RSC_CMD_WR_PAYLOAD 8'hA0
`define RSC_CMD_FLUSH_TX 8'hE1
`define RSC_CMD_FLUSH_RX 8'hE2
`define RSC_CMD_RESEND_LAST 8'hE3
`define RSC_CMD_RX_WIDTH 8'h60
`define RSC_CMD_ACK_PAY_TOP 5'h15
`define RSC_CMD_WR_NOACK 8'hB0
`define RSC_CMD_NO_OPERATION 8'hFF
`define RSC_ACK_PIPE_MAX 3'h5
// ---------------------------------------------
// sizes
// ---------------------------------------------
`define RSC_REG_BYTES_MAX 6'h05
`define RSC_PAYLOAD_BYTES 6'h20
`define RSC_FIFO_LEVELS 2'h3
`define RSC_TOKEN_FIFO_DEPTH 32
// ---------------------------------------------
// status register layout and reset values
// ---------------------------------------------
`define RSC_STATUS_REG_ADDR 5'h07
`define RSC_STATUS_RECEIVED_BIT 6
`define RSC_STATUS_SENT_BIT 5
`define RSC_STATUS_RETRY_BIT 4
`define RSC_PIPE_RESET 3'h7
`define RSC_IDLE_READ_BYTE 8'h00
`endif

//--- rtl/rsc_pkg.sv
package rsc_pkg;
	// token kinds passed from the serial side to the executor
	typedef enum logic [1:0] {
		RSC_TOK_CMD,
		RSC_TOK_DATA,
		RSC_TOK_END
	} rsc_tok_type;

	// command classes after decode
	typedef enum logic [2:0] {
		RSC_CL_NONE,
		RSC_CL_REG_WR,
		RSC_CL_TX_PAY,
		RSC_CL_ACK_PAY,
		RSC_CL_NOACK_PAY
	} rsc_class_type;

	typedef logic [2:0][31:0][7:0] rsc_mem_type;
endpackage

//--- test/rsc_spi_master.sv
// ---------------------------------------------
// controller side: serial master, mode 0
// ---------------------------------------------
module rsc_spi_master (
	input wire logic clk,
	output logic radio_select_n,
	output logic spi_sck,
	output logic spi_mosi,
	input wire logic spi_miso
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rx_q[$];
	initial begin
		radio_select_n = 1'b1;
		spi_sck = 1'b0;
		spi_mosi = 1'b1;
	end
	// half of a 125 ns link clock period
	task automatic half();
		#62.5;
	endtask
	// one command frame, bytes in wire order
	task automatic frame(input logic [7:0] q[$]);
		logic [7:0] b;
		rx_q = {};
		@(posedge clk);
		radio_select_n <= 1'b0;
		foreach (q[i]) begin
			for (int k = 7; k >= 0; k--) begin
				spi_mosi <= q[i][k];
				half();
				spi_sck <= 1'b1;
				b[k] = spi_miso;
				half();
				spi_sck <= 1'b0;
			end
			rx_q.push_back(b);
		end
		half();
		radio_select_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		half();
	endtask
endmodule // rsc_spi_master

//--- test/rsc_top_checker.sv
module rsc_top_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic radio_select_n,
	input wire logic radio_standby,
	input wire logic primary_receiver_mode,
	input wire logic mask_received,
	input wire logic mask_sent,
	input wire logic mask_retry,
	input wire logic ev_sent,
	input wire logic ev_received,
	input wire logic reg_wr_en,
	input wire logic [4:0] reg_wr_mask,
	input wire logic tx_full,
	input wire logic tx_empty,
	input wire logic reuse_active,
	input wire logic [7:0] status_byte,
	input wire logic radio_interrupt_line_n
);
	logic cause;
	assign cause = |(status_byte[6:4] & ~{mask_received, mask_sent, mask_retry});
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_live;
		cause [*2];
	endsequence
	sequence s_calm;
		(!cause) [*2];
	endsequence
	a_irq_raised: assert property (s_live |-> !radio_interrupt_line_n)
		else $error("interrupt line not active");
	a_irq_quiet: assert property (s_calm |-> radio_interrupt_line_n)
		else $error("interrupt line active without cause");
	a_flag_rx: assert property (ev_received |-> ##[1:2] status_byte[6])
		else $error("received flag not set");
	a_flag_tx: assert property (ev_sent |-> ##[1:2] status_byte[5])
		else $error("sent flag not set");
	a_pipe_moment: assert property (!$stable(status_byte[3:1]) |-> $fell(radio_interrupt_line_n))
		else $error("pipe field moved off the interrupt edge");
	a_wr_commit: assert property (reg_wr_en |-> radio_standby && radio_select_n ##1 !reg_wr_en)
		else $error("register write outside its window");
	a_wr_lsb_first: assert property (reg_wr_en |-> reg_wr_mask inside {5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F})
		else $error("register write mask has a gap");
	a_fifo_flags: assert property (!(tx_full && tx_empty) && status_byte[0] == tx_full && !status_byte[7])
		else $error("fifo flags inconsistent");
	a_reuse_mode: assert property ($rose(reuse_active) |-> !primary_receiver_mode)
		else $error("reuse started in receiver mode");
endmodule // rsc_top_checker

//--- test/rsc_top_tb_top.sv
module rsc_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_n, radio_select_n, spi_sck, spi_mosi, spi_miso, reg_wr_en, radio_standby, hit;
	logic primary_receiver_mode, feature_width_en, feature_ack_pay_en, feature_noack_en;
	logic mask_received, mask_sent, mask_retry, ev_sent, ev_received, ev_retry_limit;
	logic tx_head_noack, tx_head_is_ack, tx_sent_pop, tx_stalled, rx_wr_en, rx_commit, cmd_fifo_ready;
	logic tx_full, tx_empty, rx_full, rx_empty, reuse_active, radio_interrupt_line_n;
	logic [7:0] reg_rd_data, tx_rd_byte, rx_wr_byte, status_byte;
	logic [4:0] reg_rd_addr, reg_wr_addr, reg_wr_mask, tx_rd_idx, rx_wr_idx;
	logic [2:0] reg_rd_byte, rx_pipe_in, tx_head_pipe, rx_commit_pipe;
	logic [5:0] tx_head_width, pipe_link_lost, rx_commit_width;
	logic [39:0] reg_wr_data;
	logic [7:0] rb[3][32];
	int rl[3];
	int failures, n_compared, t;
	rsc_top rsc_top_i (.*);
	rsc_spi_master rsc_spi_master_i (.*);
	assign reg_rd_data = {reg_rd_addr, reg_rd_byte};
	always @(posedge clk) if (reg_wr_en === 1'b1) hit <= 1'b1;
	function automatic logic [7:0] st_exp(input logic [2:0] fl, input logic [2:0] p, input logic f);
		return {1'b0, fl, p, f};
	endfunction
	function automatic logic [7:0] rd_exp(input logic [4:0] a, input int i);
		return {a, i[2:0]};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic done();
		t++;
		$display("test %0d done", t);
	endtask
	task automatic finish_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// frame, then let the commit land and settle
	task automatic send(input logic [7:0] q[$]);
		hit = 1'b0;
		rsc_spi_master_i.frame(q);
		cyc(12);
		@(negedge clk);
	endtask
	task automatic pulse_ev(input int k);
		cyc(1);
		{ev_received, ev_sent, ev_retry_limit} <= 3'(k);
		cyc(1);
		{ev_received, ev_sent, ev_retry_limit} <= 3'h0;
		cyc(3);
		@(negedge clk);
	endtask
	task automatic rx_load(input int e);
		for (int i = 0; i < rl[e]; i++) begin
			rx_wr_en <= 1'b1;
			rx_wr_idx <= 5'(i);
			rx_wr_byte <= rb[e][i];
			cyc(1);
		end
		rx_wr_en <= 1'b0;
		rx_commit <= 1'b1;
		rx_commit_width <= 6'(rl[e]);
		rx_commit_pipe <= 3'(e);
		cyc(1);
		rx_commit <= 1'b0;
		cyc(2);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#(60000 * 8);
		failures++;
		finish_test();
	end
	initial begin
		logic [7:0] q[$];
		logic [7:0] p0[$];
		logic [39:0] ed;
		logic [4:0] a;
		int len[4];
		rst_n = 1'b0;
		{radio_standby, primary_receiver_mode, feature_width_en, feature_ack_pay_en, feature_noack_en} = '0;
		{mask_received, mask_sent, mask_retry, ev_sent, ev_received, ev_retry_limit, rx_pipe_in} = '0;
		{tx_rd_idx, tx_sent_pop, pipe_link_lost, rx_wr_en, rx_wr_idx, rx_wr_byte} = '0;
		{rx_commit, rx_commit_width, rx_commit_pipe} = '0;
		void'($urandom(41895));
		cyc(5);
		rst_n <= 1'b1;
		cyc(10);
		q = {8'hFF};
		send(q);
		chk({hit, rsc_spi_master_i.rx_q[0]}, {1'b0, st_exp(3'h0, 3'h7, 1'b0)});
		done();
		cyc(1);
		radio_standby <= 1'b1;
		for (int nb = 1; nb <= 5; nb++) begin
			a = 5'($urandom);
			q = {};
			q.push_back({3'h1, a});
			ed = '0;
			for (int j = 0; j < nb; j++) begin
				q.push_back(8'($urandom));
				ed[8*j +: 8] = q[j+1];
			end
			send(q);
			chk({hit, reg_wr_addr, reg_wr_mask}, {1'b1, a, 5'h1F >> (5 - nb)});
			chk(reg_wr_data & (40'hFF_FFFF_FFFF >> (8 * (5 - nb))), ed);
		end
		cyc(1);
		radio_standby <= 1'b0;
		q = {8'h25, 8'h5A};
		send(q);
		chk(hit, 1'b0);
		cyc(1);
		radio_standby <= 1'b1;
		a = 5'($urandom);
		q = {8'h00, 8'h00, 8'h00};
		q.push_front({3'h0, a});
		send(q);
		for (int i = 1; i < 4; i++) chk(rsc_spi_master_i.rx_q[i], rd_exp(a, i - 1));
		done();
		cyc(1);
		rx_pipe_in <= 3'h3;
		pulse_ev(4);
		chk({radio_interrupt_line_n, status_byte}, {1'b0, st_exp(3'h4, 3'h3, 1'b0)});
		q = {8'h27, 8'h40};
		send(q);
		chk({radio_interrupt_line_n, status_byte[6]}, 2'b10);
		cyc(1);
		mask_sent <= 1'b1;
		pulse_ev(2);
		chk({radio_interrupt_line_n, status_byte[5]}, 2'b11);
		q = {8'h27, 8'h20};
		send(q);
		cyc(1);
		mask_sent <= 1'b0;
		done();
		for (int e = 0; e < 4; e++) begin
			len[e] = (e == 0) ? 32 : 1 + int'($urandom % 8);
			q = {8'hA0};
			for (int i = 0; i < len[e]; i++) q.push_back(8'($urandom));
			if (e == 0) p0 = q;
			send(q);
		end
		chk({tx_full, tx_empty, status_byte[0]}, 3'b101);
		for (int i = 0; i < 32; i++) begin
			cyc(1);
			tx_rd_idx <= 5'(i);
			cyc(2);
			@(negedge clk);
			chk(tx_rd_byte, p0[i + 1]);
		end
		for (int e = 0; e < 3; e++) begin
			chk(tx_head_width, len[e]);
			cyc(1);
			tx_sent_pop <= 1'b1;
			cyc(1);
			tx_sent_pop <= 1'b0;
			cyc(4);
			@(negedge clk);
		end
		chk(tx_empty, 1'b1);
		q = {8'hB0, 8'h11};
		send(q);
		chk(tx_empty, 1'b1);
		cyc(1);
		feature_noack_en <= 1'b1;
		send(q);
		chk({tx_empty, tx_head_noack}, 2'b01);
		q = {8'hE3};
		send(q);
		chk(reuse_active, 1'b1);
		q = {8'hA0, 8'h33};
		send(q);
		chk(reuse_active, 1'b0);
		q = {8'hE3};
		send(q);
		q = {8'hE1};
		send(q);
		chk({reuse_active, tx_empty}, 2'b01);
		q = {8'hA0, 8'h44};
		send(q);
		pulse_ev(1);
		cyc(1);
		tx_sent_pop <= 1'b1;
		cyc(1);
		tx_sent_pop <= 1'b0;
		cyc(3);
		@(negedge clk);
		chk({tx_empty, radio_interrupt_line_n}, 2'b00);
		q = {8'h27, 8'h10};
		send(q);
		q = {8'hE1};
		send(q);
		chk({tx_empty, radio_interrupt_line_n}, 2'b11);
		done();
		cyc(1);
		primary_receiver_mode <= 1'b1;
		feature_width_en <= 1'b1;
		feature_ack_pay_en <= 1'b1;
		for (int e = 0; e < 3; e++) begin
			rl[e] = 1 + int'($urandom % 6);
			for (int i = 0; i < rl[e]; i++) rb[e][i] = 8'($urandom);
			rx_load(e);
		end
		@(negedge clk);
		chk({rx_full, rx_empty}, 2'b10);
		q = {8'h60, 8'h00};
		send(q);
		chk(rsc_spi_master_i.rx_q[1], rl[0]);
		q = {8'h61};
		for (int i = 0; i < rl[0]; i++) q.push_back(8'h00);
		send(q);
		for (int i = 0; i < rl[0]; i++) chk(rsc_spi_master_i.rx_q[i + 1], rb[0][i]);
		q = {8'h60, 8'h00};
		send(q);
		chk(rsc_spi_master_i.rx_q[1], rl[1]);
		q = {8'hE2};
		send(q);
		chk(rx_empty, 1'b1);
		q = {8'hAE, 8'h55};
		send(q);
		chk(tx_empty, 1'b1);
		q = {8'hA9, 8'h55};
		send(q);
		chk({tx_head_is_ack, tx_head_pipe}, 4'h9);
		cyc(1);
		pipe_link_lost <= 6'h02;
		cyc(3);
		@(negedge clk);
		chk(tx_stalled, 1'b1);
		q = {8'hE1};
		send(q);
		chk(tx_empty, 1'b1);
		done();
		cyc(1);
		q = {8'hA0};
		for (int i = 0; i < 32; i++) q.push_back(8'($urandom));
		send(q);
		chk(cmd_fifo_ready, 1'b1);
		cyc(1);
		tx_rd_idx <= 5'h1F;
		cyc(2);
		@(negedge clk);
		chk({tx_head_width, tx_rd_byte}, {6'h20, q[32]});
		chk(tx_empty, 1'b0);
		done();
		finish_test();
	end
endmodule // rsc_top_tb_top

bind rsc_top rsc_top_checker rsc_top_checker_i (.*);
